// ==== rtl/flash_pkg.sv ====
package flash_pkg;
    // ----------------------------------------------------------------
    // instruction codes (plain defaults)
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_DDR_FAST = 8'h0d;
    localparam logic [7:0] OP_DDR_DUAL = 8'hbd;
    localparam logic [7:0] OP_DDR_QUAD = 8'hed;
    localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
    localparam logic [7:0] OP_QIOR = 8'heb;
    localparam logic [7:0] OP_QUAD_PROG = 8'h32;
    localparam logic [7:0] OP_WREG = 8'h01;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_SE = 8'hd8;
    // ----------------------------------------------------------------
    // configuration fields, widths and counts
    // ----------------------------------------------------------------
    localparam int CFG_LC_HI = 7;
    localparam int CFG_LC_LO = 6;
    localparam int CFG_QUAD = 1;
    localparam logic [2:0] W1 = 3'h1;
    localparam logic [2:0] W2 = 3'h2;
    localparam logic [2:0] W4 = 3'h4;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CMD_LAST = 4'h7;
    localparam logic [5:0] ADDR_BITS = 6'h18;
    localparam logic [5:0] MODE_BITS = 6'h08;
    localparam logic [3:0] PAT_CYCLES = 4'h4;
    localparam logic [3:0] MASK_W1 = 4'h2;
    localparam logic [3:0] MASK_W2 = 4'h3;
    localparam logic [3:0] MASK_W4 = 4'hf;

    // latency cycles per code; every entry is at least one
    function automatic logic [3:0] lat_cycles(input logic [1:0] lc,
                                              input logic ddr);
        case (lc)
            2'h0: lat_cycles = ddr ? 4'h6 : 4'h8;
            2'h1: lat_cycles = ddr ? 4'h5 : 4'h4;
            2'h2: lat_cycles = ddr ? 4'h7 : 4'h5;
            default: lat_cycles = ddr ? 4'h8 : 4'h6;
        endcase
    endfunction
endpackage

// ==== rtl/flash_phase.sv ====
// Notes on behaviour
// - quad output drives all four lines
// - output phases last until select rises
// - ddr single read: address on line 0
// - ddr dual read: address on lines 0,1
// - ddr quad read: address on four lines
// - last address edge enters ddr latency
// - ddr latency at least one, from code
// - training pattern drives last four cycles
// - long latency: lines idle until last four
// - after latency, output matches the instruction
// - ddr single output only on line 1
// - ddr dual output on lines 0,1
// - ddr quad output four bits per edge
// - latency code sets cycles per read type
// - quad bit ignores hold, enables quad commands
// - ddr quad read rejected without quad mode
// - no command accepted during power-on reset
// - write-type commands need clocks multiple eight
// - hold ignored during ddr
`timescale 1ns/10ps
module flash_phase
    import flash_pkg::*;
(
    input wire logic mclk,                 // 50 MHz system clock
    input wire logic reset_n,              // async reset
    input wire logic sck,                  // serial clock pin
    input wire logic cs_n,                 // chip select pin
    input wire logic [3:0] data_line_in,   // data pins in
    output logic [3:0] data_line_out,      // data pins out
    output logic [3:0] data_line_oe,       // data pin enables
    input wire logic [7:0] configuration_register, // config bits
    input wire logic training_pattern_en,  // pattern option
    input wire logic [7:0] training_pattern, // pattern value
    input wire logic por_busy,             // power-on reset running
    input wire logic [7:0] rd_data,        // next read byte
    output logic rd_req,                   // pulse: byte wanted
    output logic [7:0] cmd_code,           // last instruction
    output logic [31:0] cmd_addr,          // address and mode
    output logic addr_done,                // pulse: address in
    output logic wr_exec,                  // pulse: write accepted
    output logic wr_ignored,               // pulse: bad clock count
    output logic ddr_active,               // ddr command running
    output logic hold_paused               // hold pause active
);
    import flash_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CMD, ST_ADDR, ST_LAT, ST_DOUT, ST_WCNT, ST_WAIT
    } st_e;

    // ----------------------------------------------------------------
    // pin synchronisers and edge detect
    // ----------------------------------------------------------------
    logic sck_m, sck_s, sck_d, cs_m, cs_s;
    logic [3:0] io_m, io_s;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sck_m <= 1'b0;
            sck_s <= 1'b0;
            sck_d <= 1'b0;
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            io_m <= 4'h0;
            io_s <= 4'h0;
        end else begin
            sck_m <= sck;
            sck_s <= sck_m;
            sck_d <= sck_s;
            cs_m <= cs_n;
            cs_s <= cs_m;
            io_m <= data_line_in;
            io_s <= io_m;
        end
    end

    st_e st_r;
    logic [7:0] op_r, sh_r, pat_r;
    logic [31:0] addr_r;
    logic [5:0] cnt_r, need_r;
    logic [3:0] lat_r, bits_r, odat_r;
    logic [2:0] win_r, wout_r, wcnt_r;
    logic ddr_r;

    wire quad = configuration_register[CFG_QUAD];
    wire [1:0] lcode = configuration_register[CFG_LC_HI:CFG_LC_LO];
    // hold shares line 3; quad mode and ddr commands ignore it
    wire pause = !quad && !io_s[3] && !ddr_r && st_r != ST_IDLE;
    wire rise = sck_s && !sck_d && !cs_s && !pause;
    wire fall = !sck_s && sck_d && !cs_s && !pause;
    // the fall right after the instruction carries no address bit
    wire in_edge = rise || (ddr_r && fall && cnt_r != 6'h00);
    wire out_edge = fall || (ddr_r && rise);

    // ----------------------------------------------------------------
    // instruction decode
    // ----------------------------------------------------------------
    // fields: ok, write, ddr, input width, output width, mode bits
    function automatic logic [9:0] decode(input logic [7:0] op,
                                          input logic q);
        case (op)
            OP_DDR_FAST: decode = {3'b101, W1, W1, 1'b1};
            OP_DDR_DUAL: decode = {3'b101, W2, W2, 1'b1};
            OP_DDR_QUAD: decode = {q, 2'b01, W4, W4, 1'b1};
            OP_QUAD_OUT: decode = {q, 2'b00, W1, W4, 1'b0};
            OP_QIOR: decode = {q, 2'b00, W4, W4, 1'b1};
            OP_QUAD_PROG: decode = {q, q, 1'b0, W4, W4, 1'b0};
            OP_WREG, OP_PP, OP_SE: decode = {3'b110, W1, W1, 1'b0};
            default: decode = 10'h000;
        endcase
    endfunction

    // shift width-many input bits into the low end
    function automatic logic [31:0] shin(input logic [31:0] a,
                                         input logic [3:0] io,
                                         input logic [2:0] w);
        case (w)
            W2: shin = {a[29:0], io[1:0]};
            W4: shin = {a[27:0], io};
            default: shin = {a[30:0], io[0]};
        endcase
    endfunction

    // top width-many bits of a byte onto the lines
    function automatic logic [3:0] place(input logic [7:0] b,
                                         input logic [2:0] w);
        case (w)
            W2: place = {2'b00, b[7:6]};
            W4: place = b[7:4];
            default: place = {2'b00, b[7], 1'b0};
        endcase
    endfunction

    wire [7:0] cmd_byte = {op_r[6:0], io_s[0]};
    wire [9:0] dec = decode(cmd_byte, quad);
    wire cmd_fin = st_r == ST_CMD && rise && cnt_r[3:0] == CMD_LAST;
    wire [5:0] cnt_inc = cnt_r + {3'b000, win_r};
    wire addr_fin = st_r == ST_ADDR && in_edge && cnt_inc == need_r;
    wire lat_fin = st_r == ST_LAT && fall && lat_r == 4'h1;
    wire out_step = lat_fin || (st_r == ST_DOUT && out_edge);
    wire [7:0] src = bits_r == 4'h0 ? rd_data : sh_r;
    wire [3:0] bits_left = (bits_r == 4'h0 ? BYTE_BITS : bits_r)
        - {1'b0, wout_r};
    wire pat_on = training_pattern_en && lat_r <= PAT_CYCLES;
    wire [3:0] omask = wout_r == W4 ? MASK_W4 :
        (wout_r == W2 ? MASK_W2 : MASK_W1);

    // ----------------------------------------------------------------
    // phase sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= ST_IDLE;
        end else if (cs_s) begin
            st_r <= ST_IDLE;
        end else begin
            case (st_r)
                ST_IDLE: st_r <= por_busy ? ST_WAIT : ST_CMD;
                ST_CMD: if (cmd_fin) begin
                    st_r <= !dec[9] ? ST_WAIT :
                        (dec[8] ? ST_WCNT : ST_ADDR);
                end
                ST_ADDR: if (addr_fin) st_r <= ST_LAT;
                ST_LAT: if (lat_fin) st_r <= ST_DOUT;
                ST_DOUT: st_r <= ST_DOUT;
                ST_WCNT: st_r <= ST_WCNT;
                ST_WAIT: st_r <= ST_WAIT;
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            op_r <= 8'h00;
            cnt_r <= 6'h00;
            need_r <= ADDR_BITS;
            ddr_r <= 1'b0;
            win_r <= W1;
            wout_r <= W1;
            addr_r <= 32'h0;
        end else if (st_r == ST_IDLE) begin
            cnt_r <= 6'h00;
            ddr_r <= 1'b0;
        end else if (st_r == ST_CMD && rise) begin
            op_r <= cmd_byte;
            cnt_r <= cmd_fin ? 6'h00 : cnt_r + 6'h01;
            if (cmd_fin) begin
                ddr_r <= dec[7];
                win_r <= dec[6:4];
                wout_r <= dec[3:1];
                need_r <= ADDR_BITS + (dec[0] ? MODE_BITS : 6'h00);
            end
        end else if (st_r == ST_ADDR && in_edge) begin
            addr_r <= shin(addr_r, io_s, win_r);
            cnt_r <= cnt_inc;
        end
    end

    // latency, pattern and output shifting
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lat_r <= 4'h0;
            pat_r <= 8'h00;
            sh_r <= 8'h00;
            bits_r <= 4'h0;
            odat_r <= 4'h0;
        end else if (addr_fin) begin
            lat_r <= lat_cycles(lcode, ddr_r);
            pat_r <= training_pattern;
            bits_r <= 4'h0;
        end else begin
            if (st_r == ST_LAT && fall && lat_r != 4'h1) begin
                lat_r <= lat_r - 4'h1;
            end
            if (st_r == ST_LAT && pat_on && (rise || fall)) begin
                pat_r <= {pat_r[6:0], pat_r[7]};
            end
            if (out_step) begin
                odat_r <= place(src, wout_r);
                sh_r <= src << wout_r;
                bits_r <= bits_left;
            end
        end
    end

    // ----------------------------------------------------------------
    // pin drive; one mclk behind the phase so lines never glitch
    // ----------------------------------------------------------------
    logic [3:0] oe_nxt, out_nxt;
    assign oe_nxt = st_r == ST_DOUT ? omask :
        (st_r == ST_LAT && pat_on ? MASK_W4 : 4'h0);
    assign out_nxt = st_r == ST_LAT ? {4{pat_r[7]}} : odat_r;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            data_line_oe <= 4'h0;
            data_line_out <= 4'h0;
        end else begin
            data_line_oe <= cs_s ? 4'h0 : oe_nxt;
            data_line_out <= out_nxt;
        end
    end

    // ----------------------------------------------------------------
    // write-type clock count and strobes
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wcnt_r <= 3'h0;
            wr_exec <= 1'b0;
            wr_ignored <= 1'b0;
            rd_req <= 1'b0;
            addr_done <= 1'b0;
        end else begin
            if (st_r != ST_WCNT) wcnt_r <= 3'h0;
            else if (rise) wcnt_r <= wcnt_r + 3'h1;
            // dropped with a wr_ignored pulse: no status is kept for a bad count
            wr_exec <= st_r == ST_WCNT && cs_s && wcnt_r == 3'h0;
            wr_ignored <= st_r == ST_WCNT && cs_s && wcnt_r != 3'h0;
            addr_done <= addr_fin;
            rd_req <= addr_fin || (out_step && bits_left == 4'h0);
        end
    end

    assign cmd_code = op_r;
    assign cmd_addr = addr_r;
    assign ddr_active = ddr_r;
    assign hold_paused = pause;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_quad_all_lines: assert property (@(posedge mclk) disable iff
        (!reset_n) $past(st_r) == ST_DOUT && !$past(cs_s)
        && $past(wout_r) == W4 |-> data_line_oe == MASK_W4)
        else $error("quad output not on all lines");
    a_select_ends: assert property (@(posedge mclk) disable iff
        (!reset_n) cs_s |=> st_r == ST_IDLE ##1 data_line_oe == 4'h0)
        else $error("select high did not end command");
    a_single_line: assert property (@(posedge mclk) disable iff
        (!reset_n) st_r == ST_DOUT && !cs_s && wout_r == W1
        |=> data_line_oe == MASK_W1) else $error("single out lines");
    a_dual_lines: assert property (@(posedge mclk) disable iff
        (!reset_n) st_r == ST_DOUT && !cs_s && wout_r == W2
        |=> data_line_oe == MASK_W2) else $error("dual out lines");
    a_lat_quiet: assert property (@(posedge mclk) disable iff
        (!reset_n) st_r == ST_LAT && lat_r > PAT_CYCLES
        |=> data_line_oe == 4'h0) else $error("drive in early latency");
    a_ddr_lat_entry: assert property (@(posedge mclk) disable iff
        (!reset_n) addr_fin && !cs_s |=> st_r == ST_LAT && lat_r != 4'h0
        && addr_done) else $error("latency not entered");
    a_quad_reject: assert property (@(posedge mclk) disable iff
        (!reset_n) cmd_fin && !cs_s && cmd_byte == OP_DDR_QUAD && !quad
        |=> st_r == ST_WAIT) else $error("ddr quad taken without quad");
    a_por_block: assert property (@(posedge mclk) disable iff
        (!reset_n) st_r == ST_IDLE && !cs_s && por_busy
        |=> st_r == ST_WAIT [*2]) else $error("command taken in por");
    a_write_count: assert property (@(posedge mclk) disable iff
        (!reset_n) wr_exec |-> $past(wcnt_r) == 3'h0
        && $past(st_r) == ST_WCNT && !wr_ignored)
        else $error("write run with bad clock count");
endmodule // flash_phase

// ==== tb/flash_host_model.sv ====
`timescale 1ns/10ps
module flash_host_model (
    input wire logic mclk,                // system clock
    input wire logic [3:0] data_line_out, // device drive value
    input wire logic [3:0] data_line_oe,  // device drive enables
    output logic sck,                     // serial clock, mode 0
    output logic cs_n,                    // chip select
    output logic [3:0] data_line_in,      // resolved pin level
    output logic [3:0] seen,              // pins at mid half period
    output logic [3:0] seen_oe            // enables at mid half period
);
    logic [3:0] d_val;
    logic host_en;
    logic flip;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        d_val = 4'h0;
        host_en = 1'b0;
        flip = 1'b0;
    end
    always @(posedge mclk) flip <= ~flip;
    // a released line shows a changing level, never the last driven value
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            data_line_in[i] = data_line_oe[i] ? data_line_out[i] :
                              host_en ? d_val[i] : flip ^ i[0];
        end
    end
    task automatic start(input logic [3:0] d);
        @(posedge mclk);
        cs_n <= 1'b0;
        d_val <= d;
        host_en <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask
    // one sck edge; data for the next edge is set mid half period
    task automatic step(input logic [3:0] d, input logic en);
        sck <= ~sck;
        repeat (2) @(posedge mclk);
        seen <= data_line_in;
        seen_oe <= data_line_oe;
        d_val <= d;
        host_en <= en;
        repeat (2) @(posedge mclk);
    endtask
    task automatic stop();
        cs_n <= 1'b1;
        host_en <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
endmodule // flash_host_model

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    import flash_pkg::*;
    logic mclk, reset_n, sck, cs_n, training_pattern_en, por_busy, rd_req;
    logic addr_done, wr_exec, wr_ignored, ddr_active, hold_paused;
    logic [3:0] data_line_in, data_line_out, data_line_oe, seen, seen_oe;
    logic [7:0] configuration_register, rd_data, cmd_code;
    logic [31:0] cmd_addr;
    int err_total = 0;
    int num_checks = 0;
    int n_exec = 0;
    int n_ign = 0;
    int n_addr = 0;
    int n_rq = 0;
    localparam logic [7:0] TP_VALUE = 8'hb4;
    flash_phase u_flash_phase (.mclk(mclk), .reset_n(reset_n), .sck(sck),
        .cs_n(cs_n), .data_line_in(data_line_in),
        .data_line_out(data_line_out), .data_line_oe(data_line_oe),
        .configuration_register(configuration_register),
        .training_pattern_en(training_pattern_en),
        .training_pattern(TP_VALUE), .por_busy(por_busy), .rd_data(rd_data),
        .rd_req(rd_req), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
        .addr_done(addr_done), .wr_exec(wr_exec), .wr_ignored(wr_ignored),
        .ddr_active(ddr_active), .hold_paused(hold_paused));
    flash_host_model u_flash_host_model (.mclk(mclk),
        .data_line_out(data_line_out), .data_line_oe(data_line_oe),
        .sck(sck), .cs_n(cs_n), .data_line_in(data_line_in), .seen(seen),
        .seen_oe(seen_oe));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (wr_exec === 1'b1) n_exec <= n_exec + 1;
        if (wr_ignored === 1'b1) n_ign <= n_ign + 1;
        if (addr_done === 1'b1) n_addr <= n_addr + 1;
        if (rd_req === 1'b1) n_rq <= n_rq + 1;
    end
    // ----------------------------------------------------------------
    // compare and closing tasks
    // ----------------------------------------------------------------
    task automatic chk_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // transfers
    // ----------------------------------------------------------------
    // unused lines carry line 3 low so a honoured hold would stall
    function automatic logic [3:0] chunk(input logic [31:0] v, input int k,
                                         input int w);
        case (w)
            1: chunk = {3'b010, v[31-k]};
            2: chunk = {2'b01, v[31-2*k -: 2]};
            default: chunk = v[31-4*k -: 4];
        endcase
    endfunction
    function automatic logic [3:0] dout(input int w, input int idx);
        case (w)
            1: dout = {2'b00, rd_data[7-idx], 1'b0};
            2: dout = {2'b00, rd_data[7-2*idx -: 2]};
            default: dout = rd_data[7-4*idx -: 4];
        endcase
    endfunction
    task automatic rd(input logic [7:0] op, input int w, input logic [1:0] lc,
                      input logic quad, input logic pat);
        int lat;
        int ne;
        int j;
        int a0;
        int r0;
        logic [3:0] msk;
        logic [3:0] exp_oe;
        logic [31:0] a;
        lat = (lc == 2'h0) ? 6 : (lc == 2'h1) ? 5 : (lc == 2'h2) ? 7 : 8;
        ne = 32 / w;
        a0 = n_addr;
        r0 = n_rq;
        a = {op ^ 8'h5a, 24'hc35a96};
        msk = (w == 1) ? MASK_W1 : (w == 2) ? MASK_W2 : MASK_W4;
        if (op == OP_DDR_QUAD && !quad) msk = 4'h0;
        configuration_register <= {lc, 4'h0, quad, 1'b0};
        training_pattern_en <= pat;
        u_flash_host_model.start({3'b100, op[7]});
        for (int i = 7; i >= 0; i--) begin
            u_flash_host_model.step({3'b100, op[i]}, 1'b1);
            u_flash_host_model.step(i > 0 ? {3'b100, op[i-1]} : chunk(a, 0, w),
                                    1'b1);
        end
        for (int k = 0; k < ne; k++) begin
            u_flash_host_model.step(k < ne - 1 ? chunk(a, k + 1, w) : 4'h0,
                                    k < ne - 1);
        end
        for (int e = 0; e < 2 * lat + 4; e++) begin
            u_flash_host_model.step(4'h0, 1'b0);
            j = e - 1;
            if (e == 0 && msk != 4'h0) begin
                chk_val("cmd_addr", a, cmd_addr);
                chk_val("ddr_active", 32'h1, {31'h0, ddr_active});
                chk_val("cmd_code", {24'h0, op}, {24'h0, cmd_code});
                chk_val("hold_paused", 32'h0, {31'h0, hold_paused});
            end
            exp_oe = (j >= 2 * lat - 1) ? msk :
                     (pat && msk != 4'h0 && j >= 2 * lat - 9) ? 4'hf : 4'h0;
            chk_val("oe", {28'h0, exp_oe},
                    {28'h0, seen_oe});
            // pattern bits go out msb first, one new bit per edge
            if (exp_oe == 4'hf && j < 2 * lat - 1)
                chk_val("pattern", {28'h0, {4{TP_VALUE[2 * lat - 2 - j]}}},
                        {28'h0, seen});
            if (msk != 4'h0 && (j == 2 * lat - 1 || j == 2 * lat))
                chk_val("data", {28'h0, dout(w, j - 2 * lat + 1) & msk},
                        {28'h0, seen & msk});
        end
        u_flash_host_model.stop();
        chk_val("oe idle", 32'h0, {28'h0, data_line_oe});
        chk_val("addr_done", {31'h0, msk != 4'h0}, n_addr - a0);
        // first byte at address end, then one per byte used in five edges
        chk_val("rd_req", msk != 4'h0 ? 1 + 5 * w / 8 : 0, n_rq - r0);
        $display("test read %h lc %0d done", op, lc);
    endtask
    task automatic wr(input logic [7:0] op, input int n, input logic por,
                      input logic ok);
        int e0;
        int i0;
        e0 = n_exec;
        i0 = n_ign;
        por_busy <= por;
        configuration_register <= 8'h00;
        u_flash_host_model.start({3'b100, op[7]});
        for (int i = 0; i < n; i++) begin
            u_flash_host_model.step({3'b100, i < 8 ? op[7-i] : 1'b0}, 1'b1);
            u_flash_host_model.step({3'b100, i < 7 ? op[6-i] : 1'b0}, 1'b1);
        end
        u_flash_host_model.stop();
        chk_val("wr_exec", {31'h0, ok}, n_exec - e0);
        chk_val("wr_ignored", {31'h0, !ok && !por}, n_ign - i0);
        por_busy <= 1'b0;
        $display("test write %h clocks %0d done", op, n);
    endtask
    initial begin
        reset_n = 1'b0;
        configuration_register = 8'h00;
        training_pattern_en = 1'b0;
        por_busy = 1'b0;
        rd_data = 8'h9c;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(OP_DDR_QUAD, 4, 2'h0, 1'b1, 1'b1);
        rd(OP_DDR_FAST, 1, 2'h1, 1'b0, 1'b0);
        rd(OP_DDR_DUAL, 2, 2'h2, 1'b0, 1'b1);
        rd(OP_DDR_QUAD, 4, 2'h3, 1'b1, 1'b0);
        rd(OP_DDR_QUAD, 4, 2'h0, 1'b0, 1'b1);
        wr(OP_PP, 32, 1'b0, 1'b1);
        wr(OP_PP, 33, 1'b0, 1'b0);
        wr(OP_WREG, 16, 1'b0, 1'b1);
        wr(OP_SE, 31, 1'b0, 1'b0);
        wr(OP_SE, 32, 1'b1, 1'b0);
        report_and_stop();
    end
    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end
endmodule // tb_top
